//--- hw/sfc_defines.vh
// Opcodes, command codes and sizes of the serial flash command front end
`ifndef SFC_DEFINES_VH
`define SFC_DEFINES_VH

`define SFC_OP_WREN 8'h06
`define SFC_OP_VSREN 8'h50
`define SFC_OP_WRDI 8'h04
`define SFC_OP_RELPD 8'hab
`define SFC_OP_READ 8'h03
`define SFC_OP_FREAD 8'h0b
`define SFC_OP_PROG 8'h02
`define SFC_OP_SERASE 8'h20
`define SFC_OP_BERASE32 8'h52
`define SFC_OP_BERASE64 8'hd8
`define SFC_OP_CERASE_A 8'hc7
`define SFC_OP_CERASE_B 8'h60
`define SFC_OP_RDSR1 8'h05
`define SFC_OP_RDSR2 8'h35
`define SFC_OP_RDSR3 8'h15
`define SFC_OP_WRSR1 8'h01
`define SFC_OP_WRSR2 8'h31
`define SFC_OP_WRSR3 8'h11
`define SFC_OP_SECERASE 8'h44
`define SFC_OP_SECPROG 8'h42
`define SFC_OP_SECREAD 8'h48
`define SFC_OP_GLOCK 8'h7e
`define SFC_OP_GUNLOCK 8'h98
`define SFC_OP_RDLOCK 8'h3d
`define SFC_OP_LOCK 8'h36
`define SFC_OP_UNLOCK 8'h39
`define SFC_OP_SUSPEND 8'h75
`define SFC_OP_RESUME 8'h7a
`define SFC_OP_PDOWN 8'hb9
`define SFC_OP_RSTEN 8'h66
`define SFC_OP_RST 8'h99

// Command codes handed to the array engine
`define SFC_CMD_NONE 4'h0
`define SFC_CMD_SERASE 4'h1
`define SFC_CMD_BERASE32 4'h2
`define SFC_CMD_BERASE64 4'h3
`define SFC_CMD_CERASE 4'h4
`define SFC_CMD_PROG 4'h5
`define SFC_CMD_WRSR 4'h6
`define SFC_CMD_SECERASE 4'h7
`define SFC_CMD_SECPROG 4'h8
`define SFC_CMD_SUSPEND 4'h9
`define SFC_CMD_RESUME 4'ha
`define SFC_CMD_PDOWN 4'hb
`define SFC_CMD_RESET 4'hc

// Bits per byte, address bytes, page size, block count
`define SFC_BYTE_BITS 4'h8
`define SFC_ADDR_BYTES 10'h003
`define SFC_PAGE_BYTES 9'h100
`define SFC_NUM_BLOCKS 128
`define SFC_BYTE_CNT_MAX 10'h3fe
// Identifier shifted out after release from power-down (arbitrary value)
`define SFC_DEVICE_ID 8'h5a

`endif

//--- hw/sfc_sync.v
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sfc_sync #(
   parameter W = 3,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   input wire clock, // System clock
   input wire rst_n, // Synchronous reset, active low
   input wire [W-1:0] in_d, // Asynchronous inputs
   output wire [W-1:0] out_q // Synchronised outputs
);
   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;

   always @(posedge clock) begin
      if (!rst_n) begin
         meta_r <= RST_VAL;
         sync_r <= RST_VAL;
      end else begin
         meta_r <= in_d;
         sync_r <= meta_r;
      end
   end

   assign out_q = sync_r;
endmodule // sfc_sync

//--- hw/sfc_front_end.v
// Serial flash instruction front end: framing, decode, gating, protection
//
// Function
// - Drop erase or program whose target touches any protected area.
// - Block lock bits protect only when block select is 1, else range.
// - All block lock bits are 1 after reset.
// - Falling chip select starts instruction; first byte is opcode.
// - Serial input sampled on rising clock edge, MSB first.
// - Rising chip select ends the current instruction.
// - Opcode may be followed by address, data and dummy bytes.
// - Reads may end after any bit.
// - Write, program, erase ignored unless ended on a byte boundary.
// - While busy, ignore everything except status reads and 75h suspend.
// - Eight clocks per byte; 06h, 50h and 04h handle write enables.
// - 75h suspends and 7Ah resumes erase or program.
// - B9h enters power-down; ABh leaves it, ID after three dummies.
// - Security 44h erase, 42h program, 48h read with one dummy.
// - Every byte position takes eight clocks.
// - Write enable latch must be set before program, erase, SR write (or 50h for SR write).
// - Latch clears at reset and on issuing writes, erases, reset.
// - Program takes 1 to 256 bytes, wrapping within the page.
`timescale 1ns/1ps
`include "sfc_defines.vh"
module sfc_front_end (
   input wire clock, // System clock
   input wire rst_n, // Synchronous reset, active low
   input wire cs_n_pin, // Chip select pin, active low
   input wire sck_pin, // Serial clock pin
   input wire serial_input_pin, // Serial data in
   input wire busy, // Array cycle in progress
   input wire per_block_protect_select, // 1 = block locks protect
   input wire prot_en, // Status range protection active
   input wire [23:0] prot_lo, // First protected address
   input wire [23:0] prot_hi, // Last protected address
   input wire [7:0] sr1, // Status register 1 value
   input wire [7:0] sr2, // Status register 2 value
   input wire [7:0] sr3, // Status register 3 value
   input wire [7:0] rd_data, // Array read byte for rd_addr_r
   input wire [7:0] pg_raddr, // Page buffer read index
   output reg so_r, // Serial data out
   output reg so_en_n_r, // Serial out enable, active low
   output reg cmd_valid_r, // Command pulse to array engine
   output reg [3:0] cmd_code_r, // Command code
   output reg [23:0] cmd_addr_r, // Command address
   output reg [8:0] cmd_len_r, // Program byte count
   output reg [7:0] cmd_data_r, // Status write data
   output reg [1:0] cmd_sr_sel_r, // Status register selected
   output reg cmd_vol_r, // Status write is volatile
   output reg rd_req_r, // Array read request pulse
   output reg [23:0] rd_addr_r, // Array read address
   output reg [7:0] pg_rdata_r, // Page buffer read data
   output reg write_enable_latch_r, // Write enable latch
   output reg pd_r // Power-down state
);
   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function [3:0] sfc_dstart; // First data byte position, 0 = no read
      input [7:0] op;
      begin
         case (op)
            `SFC_OP_RDSR1, `SFC_OP_RDSR2, `SFC_OP_RDSR3: sfc_dstart = 4'h1;
            `SFC_OP_READ, `SFC_OP_RDLOCK, `SFC_OP_RELPD: sfc_dstart = 4'h4;
            `SFC_OP_FREAD, `SFC_OP_SECREAD: sfc_dstart = 4'h5;
            default: sfc_dstart = 4'h0;
         endcase
      end
   endfunction

   function sfc_ignore; // Opcode refused in the present state
      input [7:0] op;
      input bsy;
      input pd;
      begin
         if (pd)
            sfc_ignore = (op != `SFC_OP_RELPD);
         else if (bsy)
            sfc_ignore = !(op == `SFC_OP_RDSR1 || op == `SFC_OP_RDSR2 ||
               op == `SFC_OP_RDSR3 || op == `SFC_OP_SUSPEND);
         else
            sfc_ignore = 1'b0;
      end
   endfunction

   function [23:0] sfc_mask; // Address bits inside the target region
      input [3:0] code;
      begin
         case (code)
            `SFC_CMD_SERASE: sfc_mask = 24'h000fff;
            `SFC_CMD_BERASE32: sfc_mask = 24'h007fff;
            `SFC_CMD_BERASE64: sfc_mask = 24'h00ffff;
            `SFC_CMD_CERASE: sfc_mask = 24'hffffff;
            default: sfc_mask = 24'h0000ff;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // Pin sampling and edge detection
   // ----------------------------------------------------------------
   wire cs_s;
   wire sck_s;
   wire si_s;
   reg cs_d_r;
   reg sck_d_r;

   sfc_sync #(.W(3), .RST_VAL(3'h4)) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .in_d({cs_n_pin, sck_pin, serial_input_pin}),
      .out_q({cs_s, sck_s, si_s})
   );

   wire cs_fall = cs_d_r & ~cs_s;
   wire cs_rise = ~cs_d_r & cs_s;
   wire sck_rise = ~sck_d_r & sck_s & ~cs_s;
   wire sck_fall = sck_d_r & ~sck_s & ~cs_s;

   // ----------------------------------------------------------------
   // Instruction state
   // ----------------------------------------------------------------
   reg [2:0] bit_r;
   reg [9:0] byte_r;
   reg [6:0] sh_r;
   reg [7:0] opcode_r;
   reg [23:0] addr_r;
   reg [23:0] raddr_r;
   reg [7:0] b1_r;
   reg [7:0] pidx_r;
   reg [8:0] pcnt_r;
   reg [7:0] out_r;
   reg ign_r;
   reg load_pend_r;
   reg vsr_r;
   reg rst_en_r;
   reg [`SFC_NUM_BLOCKS-1:0] lock_r;
   reg [7:0] page_mem [0:255];

   wire [7:0] rx_byte = {sh_r, si_s};
   wire byte_done = sck_rise & (bit_r == 3'h7);
   wire first_byte = (byte_r == 10'h000);
   wire [7:0] cur_op = first_byte ? rx_byte : opcode_r;
   wire ign_now = first_byte ? sfc_ignore(rx_byte, busy, pd_r) : ign_r;
   wire [3:0] dst = sfc_dstart(cur_op);
   wire rd_phase = ~ign_now & (dst != 4'h0) &
      ((byte_r + 10'h001) >= {6'h00, dst});
   wire arr_rd = (cur_op == `SFC_OP_READ) || (cur_op == `SFC_OP_FREAD) ||
      (cur_op == `SFC_OP_SECREAD);
   wire [23:0] req_addr = (byte_r == `SFC_ADDR_BYTES) ?
      {addr_r[15:0], rx_byte} : (dst[0] && byte_r == 10'h004) ? addr_r :
      raddr_r;
   wire is_prog = (opcode_r == `SFC_OP_PROG) ||
      (opcode_r == `SFC_OP_SECPROG);

   // Source byte of a read in its data phase
   reg [7:0] src_byte;
   always @* begin
      case (opcode_r)
         `SFC_OP_RDSR1: src_byte = sr1;
         `SFC_OP_RDSR2: src_byte = sr2;
         `SFC_OP_RDSR3: src_byte = sr3;
         `SFC_OP_RELPD: src_byte = `SFC_DEVICE_ID;
         `SFC_OP_RDLOCK: src_byte = {7'h00, lock_r[addr_r[22:16]]};
         default: src_byte = rd_data;
      endcase
   end

   // ----------------------------------------------------------------
   // Decode at end of instruction
   // ----------------------------------------------------------------
   reg [3:0] end_code;
   reg end_wr;
   always @* begin
      end_code = `SFC_CMD_NONE;
      end_wr = 1'b1;
      case (opcode_r)
         `SFC_OP_SERASE: end_code = `SFC_CMD_SERASE;
         `SFC_OP_BERASE32: end_code = `SFC_CMD_BERASE32;
         `SFC_OP_BERASE64: end_code = `SFC_CMD_BERASE64;
         `SFC_OP_CERASE_A, `SFC_OP_CERASE_B: end_code = `SFC_CMD_CERASE;
         `SFC_OP_PROG: end_code = `SFC_CMD_PROG;
         `SFC_OP_WRSR1, `SFC_OP_WRSR2, `SFC_OP_WRSR3:
            end_code = `SFC_CMD_WRSR;
         `SFC_OP_SECERASE: end_code = `SFC_CMD_SECERASE;
         `SFC_OP_SECPROG: end_code = `SFC_CMD_SECPROG;
         default: end_wr = 1'b0;
      endcase
   end

   // Expected length check for each write type
   reg len_ok;
   always @* begin
      case (end_code)
         `SFC_CMD_CERASE: len_ok = (byte_r == 10'h001);
         `SFC_CMD_PROG, `SFC_CMD_SECPROG: len_ok = (byte_r >= 10'h005);
         `SFC_CMD_WRSR: len_ok = (byte_r >= 10'h002);
         default: len_ok = (byte_r == 10'h004);
      endcase
   end

   wire [23:0] rmask = sfc_mask(end_code);
   wire [23:0] r_start = addr_r & ~rmask;
   wire [23:0] r_end = addr_r | rmask;
   wire arr_target = (end_code != `SFC_CMD_WRSR) &&
      (end_code != `SFC_CMD_SECERASE) && (end_code != `SFC_CMD_SECPROG);
   wire lock_hit = (end_code == `SFC_CMD_CERASE) ? (|lock_r) :
      lock_r[addr_r[22:16]];
   wire range_hit = prot_en && (r_start <= prot_hi) && (r_end >= prot_lo);
   wire prot_hit = arr_target &&
      (per_block_protect_select ? lock_hit : range_hit);
   wire boundary = (bit_r == 3'h0);
   wire wr_allowed = write_enable_latch_r ||
      (end_code == `SFC_CMD_WRSR && vsr_r);
   wire issue_wr = end_wr && boundary && len_ok && wr_allowed &&
      !prot_hit;
   wire simple_ok = boundary && (byte_r == 10'h001);
   wire lock_ok = boundary && write_enable_latch_r;

   // ----------------------------------------------------------------
   // Page buffer
   // ----------------------------------------------------------------
   always @(posedge clock) begin
      if (byte_done && !ign_r && is_prog && byte_r > `SFC_ADDR_BYTES)
         page_mem[pidx_r] <= rx_byte;
      pg_rdata_r <= page_mem[pg_raddr];
   end

   // ----------------------------------------------------------------
   // Main sequencing
   // ----------------------------------------------------------------
   always @(posedge clock) begin
      if (!rst_n) begin
         cs_d_r <= 1'b1;
         sck_d_r <= 1'b0;
         bit_r <= 3'h0;
         byte_r <= 10'h000;
         sh_r <= 7'h00;
         opcode_r <= 8'h00;
         addr_r <= 24'h000000;
         raddr_r <= 24'h000000;
         b1_r <= 8'h00;
         pidx_r <= 8'h00;
         pcnt_r <= 9'h000;
         out_r <= 8'h00;
         ign_r <= 1'b0;
         load_pend_r <= 1'b0;
         vsr_r <= 1'b0;
         rst_en_r <= 1'b0;
         lock_r <= {`SFC_NUM_BLOCKS{1'b1}};
         so_r <= 1'b0;
         so_en_n_r <= 1'b1;
         cmd_valid_r <= 1'b0;
         cmd_code_r <= `SFC_CMD_NONE;
         cmd_addr_r <= 24'h000000;
         cmd_len_r <= 9'h000;
         cmd_data_r <= 8'h00;
         cmd_sr_sel_r <= 2'h0;
         cmd_vol_r <= 1'b0;
         rd_req_r <= 1'b0;
         rd_addr_r <= 24'h000000;
         write_enable_latch_r <= 1'b0;
         pd_r <= 1'b0;
      end else begin
         cs_d_r <= cs_s;
         sck_d_r <= sck_s;
         cmd_valid_r <= 1'b0;
         rd_req_r <= 1'b0;
         if (cs_fall) begin
            bit_r <= 3'h0;
            byte_r <= 10'h000;
            ign_r <= 1'b0;
            load_pend_r <= 1'b0;
            pcnt_r <= 9'h000;
         end
         if (sck_rise) begin
            sh_r <= rx_byte[6:0];
            bit_r <= bit_r + 3'h1;
         end
         if (byte_done) begin
            if (byte_r != `SFC_BYTE_CNT_MAX)
               byte_r <= byte_r + 10'h001;
            if (first_byte) begin
               opcode_r <= rx_byte;
               ign_r <= ign_now;
            end
            if (byte_r == 10'h001)
               b1_r <= rx_byte;
            if (!first_byte && byte_r <= `SFC_ADDR_BYTES)
               addr_r <= {addr_r[15:0], rx_byte};
            if (byte_r == `SFC_ADDR_BYTES)
               pidx_r <= rx_byte;
            if (!ign_r && is_prog && byte_r > `SFC_ADDR_BYTES) begin
               pidx_r <= pidx_r + 8'h01;
               if (pcnt_r != `SFC_PAGE_BYTES)
                  pcnt_r <= pcnt_r + 9'h001;
            end
            if (rd_phase) begin
               load_pend_r <= 1'b1;
               if (arr_rd) begin
                  rd_req_r <= 1'b1;
                  rd_addr_r <= req_addr;
                  raddr_r <= req_addr + 24'h000001;
               end
            end
         end
         if (sck_fall && !ign_r && (sfc_dstart(opcode_r) != 4'h0)) begin
            if (load_pend_r) begin
               out_r <= src_byte;
               so_r <= src_byte[7];
               so_en_n_r <= 1'b0;
               load_pend_r <= 1'b0;
            end else begin
               out_r <= {out_r[6:0], 1'b0};
               so_r <= out_r[6];
            end
         end
         if (cs_rise) begin
            so_en_n_r <= 1'b1;
            if (!ign_r && byte_r != 10'h000) begin
               rst_en_r <= (opcode_r == `SFC_OP_RSTEN) && simple_ok;
               if (issue_wr) begin
                  cmd_valid_r <= 1'b1;
                  cmd_code_r <= end_code;
                  cmd_addr_r <= addr_r;
                  cmd_len_r <= pcnt_r;
                  cmd_data_r <= b1_r;
                  cmd_sr_sel_r <= (opcode_r == `SFC_OP_WRSR1) ? 2'h1 :
                     (opcode_r == `SFC_OP_WRSR2) ? 2'h2 : 2'h3;
                  cmd_vol_r <= vsr_r && !write_enable_latch_r;
                  write_enable_latch_r <= 1'b0;
                  if (end_code == `SFC_CMD_WRSR)
                     vsr_r <= 1'b0;
               end
               case (opcode_r)
                  `SFC_OP_WREN:
                     if (simple_ok)
                        write_enable_latch_r <= 1'b1;
                  `SFC_OP_WRDI:
                     if (simple_ok)
                        write_enable_latch_r <= 1'b0;
                  `SFC_OP_VSREN:
                     if (simple_ok)
                        vsr_r <= 1'b1;
                  `SFC_OP_SUSPEND, `SFC_OP_RESUME, `SFC_OP_PDOWN:
                     if (simple_ok) begin
                        cmd_valid_r <= 1'b1;
                        cmd_code_r <= (opcode_r == `SFC_OP_SUSPEND) ?
                           `SFC_CMD_SUSPEND :
                           (opcode_r == `SFC_OP_RESUME) ?
                           `SFC_CMD_RESUME : `SFC_CMD_PDOWN;
                        if (opcode_r == `SFC_OP_PDOWN)
                           pd_r <= 1'b1;
                     end
                  `SFC_OP_RELPD:
                     pd_r <= 1'b0;
                  `SFC_OP_RST:
                     if (simple_ok && rst_en_r) begin
                        cmd_valid_r <= 1'b1;
                        cmd_code_r <= `SFC_CMD_RESET;
                        write_enable_latch_r <= 1'b0;
                        vsr_r <= 1'b0;
                     end
                  `SFC_OP_GLOCK:
                     if (lock_ok && byte_r == 10'h001)
                        lock_r <= {`SFC_NUM_BLOCKS{1'b1}};
                  `SFC_OP_GUNLOCK:
                     if (lock_ok && byte_r == 10'h001)
                        lock_r <= {`SFC_NUM_BLOCKS{1'b0}};
                  `SFC_OP_LOCK:
                     if (lock_ok && byte_r == 10'h004)
                        lock_r[addr_r[22:16]] <= 1'b1;
                  `SFC_OP_UNLOCK:
                     if (lock_ok && byte_r == 10'h004)
                        lock_r[addr_r[22:16]] <= 1'b0;
                  default: ;
               endcase
            end
         end
      end
   end
endmodule // sfc_front_end

//--- dv/sfc_host_model.sv
// Host controller model driving chip select, serial clock and data
`timescale 1ns/1ps
module sfc_host_model (
   output logic cs_n, // Chip select, active low
   output logic sck, // Serial clock, idles low
   output logic si, // Data to the device
   input wire so // Data from the device
);
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end
   // ----------------------------------------
   // Frame control
   // ----------------------------------------
   task automatic start();
      #37 cs_n = 1'b0;
   endtask
   // Data held two device clocks around both clock edges
   task automatic shift(input logic [7:0] b, input int n,
      output logic [7:0] r);
      r = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         #50 si = b[i];
         #50 sck = 1'b1;
         #90 r[i] = so;
         #10 sck = 1'b0;
      end
   endtask
   // Released data line stops showing the last bit
   task automatic stop();
      #100 cs_n = 1'b1;
      #50 si = ~si;
      #350;
   endtask
endmodule // sfc_host_model

//--- dv/sfc_front_end_asserts.sv
// Concurrent checks on the flash command front end ports
`timescale 1ns/1ps
`include "sfc_defines.vh"
module sfc_front_end_asserts (
   input wire clock, // System clock
   input wire rst_n, // Sync reset, active low
   input wire cs_n_pin, // Chip select pin
   input wire sck_pin, // Serial clock pin
   input wire busy, // Array cycle running
   input wire so_r, // Serial out
   input wire so_en_n_r, // Out enable, active low
   input wire cmd_valid_r, // Command pulse
   input wire [3:0] cmd_code_r, // Command code
   input wire [8:0] cmd_len_r, // Program count
   input wire cmd_vol_r, // Volatile status write
   input wire rd_req_r, // Read request
   input wire write_enable_latch_r, // Write enable latch
   input wire pd_r // Power-down
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire wr_cmd = cmd_valid_r && (cmd_code_r >= `SFC_CMD_SERASE) &&
      (cmd_code_r <= `SFC_CMD_SECPROG);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   a_cmd_one_pulse: assert property (cmd_valid_r |=> !cmd_valid_r)
      else $error("command pulse longer than one cycle");
   a_cmd_after_cs: assert property (
      cmd_valid_r |-> cs_n_pin && $past(cs_n_pin, 3))
      else $error("command issued inside a frame");
   a_latch_needed: assert property (
      wr_cmd && !cmd_vol_r |-> $past(write_enable_latch_r))
      else $error("write command without latch");
   a_latch_clears: assert property (
      wr_cmd |-> ##[0:1] !write_enable_latch_r)
      else $error("latch kept after write command");
   a_busy_ignores: assert property (
      cmd_valid_r && (cmd_code_r != `SFC_CMD_SUSPEND) |-> !$past(busy))
      else $error("command issued while busy");
   a_so_on_fall: assert property (
      $changed(so_r) && !so_en_n_r |-> !$past(sck_pin) && !$past(sck_pin, 2))
      else $error("serial out moved outside a falling edge");
   a_so_en_window: assert property (!so_en_n_r |-> !$past(cs_n_pin, 5))
      else $error("output enabled after frame end");
   a_pd_entry: assert property (
      cmd_valid_r && (cmd_code_r == `SFC_CMD_PDOWN) |-> ##[0:1] pd_r)
      else $error("power-down not entered");
   a_prog_len: assert property (
      cmd_valid_r && (cmd_code_r == `SFC_CMD_PROG) |->
      (cmd_len_r >= 9'h001) && (cmd_len_r <= 9'h100))
      else $error("program length out of range");
   a_rd_in_frame: assert property (
      rd_req_r |-> !$past(cs_n_pin, 3) ##1 !rd_req_r)
      else $error("read request outside a frame");
endmodule // sfc_front_end_asserts

bind sfc_front_end sfc_front_end_asserts u_chk (.clock, .rst_n, .cs_n_pin,
   .sck_pin, .busy, .so_r, .so_en_n_r, .cmd_valid_r, .cmd_code_r,
   .cmd_len_r, .cmd_vol_r, .rd_req_r, .write_enable_latch_r, .pd_r);

//--- dv/sfc_front_end_test.sv
// Self-checking bench for the flash command front end
`timescale 1ns/1ps
`include "sfc_defines.vh"
module sfc_front_end_test;
   logic clock, rst_n, busy, per_block_protect_select, prot_en;
   logic [23:0] prot_lo, prot_hi, a;
   logic [7:0] sr1, sr2, sr3, rd_data, pg_raddr, v;
   wire cs_n_pin, sck_pin, serial_input_pin, so_r, so_en_n_r, cmd_valid_r;
   wire cmd_vol_r, rd_req_r, write_enable_latch_r, pd_r;
   wire [3:0] cmd_code_r;
   wire [23:0] cmd_addr_r, rd_addr_r;
   wire [8:0] cmd_len_r;
   wire [7:0] cmd_data_r, pg_rdata_r;
   wire [1:0] cmd_sr_sel_r;
   wire so_line = so_en_n_r ? ~so_r : so_r;
   logic [7:0] tx[$], rx[$], d[0:257];
   logic [7:0] er_op[5] = '{8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
   logic [7:0] rd_op[3] = '{8'h05, 8'h35, 8'h15};
   logic [7:0] wr_op[3] = '{8'h01, 8'h31, 8'h11};
   int n_pg[2] = '{1, 258};
   int n_mismatch = 0, cmp_count = 0, n_cmd = 0;

   sfc_front_end u_dut (.clock, .rst_n, .cs_n_pin, .sck_pin,
      .serial_input_pin, .busy, .per_block_protect_select, .prot_en,
      .prot_lo, .prot_hi, .sr1, .sr2, .sr3, .rd_data, .pg_raddr, .so_r,
      .so_en_n_r, .cmd_valid_r, .cmd_code_r, .cmd_addr_r, .cmd_len_r,
      .cmd_data_r, .cmd_sr_sel_r, .cmd_vol_r, .rd_req_r, .rd_addr_r,
      .pg_rdata_r, .write_enable_latch_r, .pd_r);
   sfc_host_model u_host (.cs_n(cs_n_pin), .sck(sck_pin),
      .si(serial_input_pin), .so(so_line));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock) if (cmd_valid_r === 1'b1) n_cmd <= n_cmd + 1;
   // ----------------------------------------
   // Expectations and helpers
   // ----------------------------------------
   function automatic [3:0] erase_code(input [7:0] o);
      case (o)
         8'h20: return `SFC_CMD_SERASE;
         8'h52: return `SFC_CMD_BERASE32;
         8'hd8: return `SFC_CMD_BERASE64;
         default: return `SFC_CMD_CERASE;
      endcase
   endfunction
   // Last byte that landed on page offset j after n data bytes
   function automatic [7:0] pg_exp(input int n, input int j);
      int k;
      k = j;
      while (k + 256 < n) k += 256;
      return d[k];
   endfunction
   task automatic check(input logic [31:0] seen, exp, input string msg);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: %s seen %0h expected %0h", $time, msg,
            seen, exp);
      end
   endtask
   task automatic send(input int tail, input int exp_n);
      logic [7:0] r;
      int n0;
      n0 = n_cmd;
      rx.delete();
      u_host.start();
      foreach (tx[i]) begin
         u_host.shift(tx[i], 8, r);
         rx.push_back(r);
      end
      if (tail > 0) u_host.shift(8'h00, tail, r);
      u_host.stop();
      tx.delete();
      @(negedge clock);
      check(n_cmd - n0, exp_n, "command count");
   endtask
   task automatic op(input logic [7:0] b, input int exp_n);
      tx = '{b};
      send(0, exp_n);
   endtask
   task automatic print_verdict();
      $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #2_500_000;
      n_mismatch++;
      print_verdict();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst_n = 1'b0;
      busy = 1'b0;
      per_block_protect_select = 1'b1;
      prot_en = 1'b0;
      prot_lo = 24'h000000;
      prot_hi = 24'h000000;
      pg_raddr = 8'h00;
      void'($urandom(32'h88a31879));
      {sr1, sr2, sr3, rd_data} = $urandom;
      a = {1'b0, 23'($urandom)};
      repeat (10) @(negedge clock);
      rst_n = 1'b1;
      repeat (4) @(negedge clock);
      check({pd_r, so_en_n_r, write_enable_latch_r}, 3'b010, "reset");
      op(8'h06, 0);
      check(write_enable_latch_r, 1, "latch set");
      tx = '{8'h20, a[23:16], a[15:8], a[7:0]};
      send(0, 0);
      op(8'h04, 0);
      check(write_enable_latch_r, 0, "latch cleared");
      op(8'h06, 0);
      op(8'h98, 0);
      foreach (er_op[k]) begin
         op(8'h06, 0);
         tx = '{er_op[k], a[23:16], a[15:8], a[7:0]};
         if (k > 2) tx = '{er_op[k]};
         send(0, 1);
         check(cmd_code_r, erase_code(er_op[k]), "erase code");
         if (k < 3) check(cmd_addr_r, a, "erase address");
         check(write_enable_latch_r, 0, "latch after erase");
      end
      tx = '{8'h20, a[23:16], a[15:8], a[7:0]};
      send(0, 0);
      op(8'h06, 0);
      tx = '{8'h52, a[23:16], a[15:8], a[7:0]};
      send(3, 0);
      op(8'h7e, 0);
      per_block_protect_select = 1'b0;
      prot_en = 1'b1;
      prot_lo = {a[23:16], 16'h0000};
      prot_hi = {a[23:16], 16'hffff};
      tx = '{8'h20, a[23:16], a[15:8], a[7:0]};
      send(0, 0);
      tx = '{8'hd8, a[23:16] ^ 8'h40, a[15:8], a[7:0]};
      send(0, 1);
      prot_en = 1'b0;
      per_block_protect_select = 1'b1;
      op(8'h06, 0);
      op(8'h98, 0);
      foreach (n_pg[m]) begin
         op(8'h06, 0);
         tx = '{8'h02, a[23:16], a[15:8], a[7:0]};
         for (int i = 0; i < n_pg[m]; i++) begin
            d[i] = 8'($urandom);
            tx.push_back(d[i]);
         end
         send(0, 1);
         check(cmd_code_r, `SFC_CMD_PROG, "program code");
         check(cmd_len_r, n_pg[m] > 256 ? 256 : n_pg[m], "length");
         for (int j = 0; j < 3 && j < n_pg[m]; j++) begin
            pg_raddr = a[7:0] + 8'(j);
            repeat (2) @(negedge clock);
            check(pg_rdata_r, pg_exp(n_pg[m], j), "page byte");
         end
      end
      op(8'h06, 0);
      tx = '{8'h44, 8'h00, 8'h10, 8'h00};
      send(0, 1);
      check(cmd_code_r, `SFC_CMD_SECERASE, "security erase");
      op(8'h06, 0);
      tx = '{8'h42, 8'h00, 8'h20, a[7:0], 8'ha5};
      send(0, 1);
      check(cmd_code_r, `SFC_CMD_SECPROG, "security program");
      for (int k = 0; k < 3; k++) begin
         op(8'h06, 0);
         v = 8'($urandom);
         tx = '{wr_op[k], v};
         send(0, 1);
         check({cmd_code_r, cmd_sr_sel_r, cmd_data_r, cmd_vol_r},
            {`SFC_CMD_WRSR, 2'(k + 1), v, 1'b0}, "status write");
      end
      op(8'h50, 0);
      tx = '{8'h01, v};
      send(0, 1);
      check(cmd_vol_r, 1, "volatile write");
      op(8'h06, 0);
      busy = 1'b1;
      op(8'h04, 0);
      check(write_enable_latch_r, 1, "ignored while busy");
      for (int k = 0; k < 3; k++) begin
         tx = '{rd_op[k], 8'h00, 8'h00};
         send(0, 0);
         v = k == 0 ? sr1 : (k == 1 ? sr2 : sr3);
         check({rx[1], rx[2]}, {v, v}, "status read");
      end
      op(8'h75, 1);
      check(cmd_code_r, `SFC_CMD_SUSPEND, "suspend");
      busy = 1'b0;
      op(8'h7a, 1);
      check(cmd_code_r, `SFC_CMD_RESUME, "resume");
      tx = '{8'h05};
      send(3, 0);
      op(8'h04, 0);
      check(write_enable_latch_r, 0, "after cut read");
      tx = '{8'h03, a[23:16], a[15:8], a[7:0], 8'h00};
      send(0, 0);
      check(rx[4], rd_data, "read data");
      tx = '{8'h48, 8'h00, 8'h10, a[7:0], 8'h00, 8'h00};
      send(0, 0);
      check({rd_addr_r, rx[5]}, {24'h001001 + a[7:0], rd_data},
         "security read");
      op(8'hb9, 1);
      check(pd_r, 1, "power down");
      op(8'h06, 0);
      check(write_enable_latch_r, 0, "ignored in power down");
      tx = '{8'hab, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      send(0, 0);
      check({pd_r, rx[4], rx[5]}, {1'b0, `SFC_DEVICE_ID, `SFC_DEVICE_ID},
         "release and id");
      op(8'h66, 0);
      tx = '{8'h05, 8'h00};
      send(0, 0);
      op(8'h99, 0);
      op(8'h06, 0);
      op(8'h66, 0);
      op(8'h99, 1);
      check({cmd_code_r, write_enable_latch_r}, {`SFC_CMD_RESET, 1'b0},
         "software reset");
      print_verdict();
   end
endmodule // sfc_front_end_test
